// file: common/wwd_defs.vh
// constants for the window watchdog and reset timing block
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH

// clock
`define WWD_CLK_HZ 25000000

// pin probe time, microseconds, and its cycle count (rounded up)
`define WWD_PROBE_US 381
`define WWD_PROBE_CYC ((`WWD_PROBE_US * 25 + 0) )

// discharge window inside the probe, cycles
`define WWD_PROBE_DISCH_CYC 2500

// factory reset delays, milliseconds
`define WWD_RST_OPEN_MS 200
`define WWD_RST_PULL_MS 10
`define WWD_RST_OPEN_CYC (`WWD_RST_OPEN_MS * 25000)
`define WWD_RST_PULL_CYC (`WWD_RST_PULL_MS * 25000)

// capacitor reset delay limits, microseconds and milliseconds
`define WWD_CAP_MIN_US 700
`define WWD_CAP_MAX_MS 3200
`define WWD_CAP_MIN_CYC (`WWD_CAP_MIN_US * 25)
`define WWD_CAP_MAX_CYC (`WWD_CAP_MAX_MS * 25000)

// factory watchdog bounds (open or pulled-up pin, ratio 1:2.5 class), milliseconds
`define WWD_WDL_FAC_MS 22
`define WWD_WDU_FAC_MS 55
`define WWD_WDL_FAC_CYC (`WWD_WDL_FAC_MS * 25000)
`define WWD_WDU_FAC_CYC (`WWD_WDU_FAC_MS * 25000)

// capacitor window mode: lower bound as eighths of the measured upper bound
`define WWD_CAP_LOW_SHIFT 3

// pin option codes
`define WWD_OPT_OPEN 2'h0
`define WWD_OPT_PULL 2'h1
`define WWD_OPT_CAP 2'h2

// counter width
`define WWD_CW 32

`endif

// file: rtl/wwd_pin_probe.v
// probe of one timing-configuration pin: open, pulled up or capacitor
`timescale 1ns/10ps
`default_nettype none
`include "wwd_defs.vh"

module wwd_pin_probe (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_b_i,
	// control
	input wire start_i,
	input wire pin_level_i,
	// result
	output reg pull_en_o,
	output reg busy_o,
	output reg [1:0] opt_o
);

reg [`WWD_CW-1:0] cnt_ff;
reg seen_low_ff;

// pulldown during the first part; a pin that stays high under it is
// pulled up, one that recovers high later is open, one still low holds a cap
always @(posedge sys_clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		cnt_ff <= 32'h0;
		busy_o <= 1'b0;
		pull_en_o <= 1'b0;
		seen_low_ff <= 1'b0;
		opt_o <= `WWD_OPT_OPEN;
	end else if (start_i) begin
		cnt_ff <= 32'h0;
		busy_o <= 1'b1;
		pull_en_o <= 1'b1;
		seen_low_ff <= 1'b0;
	end else if (busy_o) begin
		cnt_ff <= cnt_ff + 32'h1;
		if (cnt_ff == `WWD_PROBE_DISCH_CYC - 1) begin
			pull_en_o <= 1'b0;
			seen_low_ff <= ~pin_level_i;
		end
		if (cnt_ff == `WWD_PROBE_CYC - 1) begin
			busy_o <= 1'b0;
			if (!seen_low_ff)
				opt_o <= `WWD_OPT_PULL;
			else if (pin_level_i)
				opt_o <= `WWD_OPT_OPEN;
			else
				opt_o <= `WWD_OPT_CAP;
		end
	end
end

endmodule
`default_nettype wire

// file: rtl/wwd_kick_detect.v
// falling-edge detector for the kick input
`timescale 1ns/10ps
`default_nettype none

module wwd_kick_detect (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_b_i,
	// kick
	input wire kick_i,
	output wire fall_o
);

reg prev_ff;

always @(posedge sys_clk_i or negedge rst_b_i) begin
	if (!rst_b_i)
		prev_ff <= 1'b1;
	else
		prev_ff <= kick_i;
end

assign fall_o = prev_ff & ~kick_i;

endmodule
`default_nettype wire

// file: rtl/wwd_top.v
// window watchdog with supervisor reset timing
// What this block does
// - a watchdog fault output exists apart from the system reset output.
// - while system reset is low the fault output is released high-impedance.
// - when system reset deasserts, window checking restarts and the fault output works again.
// - kick intervals between lower and upper bound keep fault high, others pull it low.
// - supply between power-on and lockout level holds system reset low regardless of sense.
// - during system reset all kicks are ignored and the fault output stays released.
// - with adequate supply, reset stays low until the sensed voltage is inside its window.
// - each reset assertion probes the reset-delay pin for 381 us to pick its option.
// - an open delay pin gives a 200 ms release delay, a pulled-up one 10 ms.
// - in capacitor mode the delay capacitor is discharged while reset is asserted, outside the probe and the release delay.
// - in capacitor mode a charge source runs after faults clear; reset releases at threshold.
// - window-time pin open or pulled up selects factory timeouts, else a capacitor sets them.
// - capacitor release delays from 700 us to 3.2 s are supported.
// - the first kick after checking starts is held only to the upper bound.
// - only falling kick edges count.
`timescale 1ns/10ps
`default_nettype none
`include "wwd_defs.vh"

module wwd_top (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_b_i,
	// supply and sense comparators
	input wire supply_above_uvlo_i,
	input wire sense_in_window_i,
	// host kick
	input wire watchdog_kick_in_i,
	// reset-delay pin
	input wire reset_delay_pin_i,
	output reg reset_delay_pin_o,
	output reg reset_delay_pin_oe_o,
	output reg delay_charge_en_o,
	// window-time pin
	input wire window_time_pin_i,
	output reg window_time_pin_o,
	output reg window_time_pin_oe_o,
	output reg window_charge_en_o,
	// outputs
	output reg system_reset_n_o,
	output reg watchdog_fault_n_o,
	output reg watchdog_fault_n_oe_o
);

localparam ST_HOLD = 2'h0;
localparam ST_PROBE = 2'h1;
localparam ST_DELAY = 2'h2;
localparam ST_RUN = 2'h3;

localparam WD_FIRST = 2'h0;
localparam WD_WIN = 2'h1;
localparam WD_FAULT = 2'h2;
localparam WD_CAL = 2'h3;

reg [1:0] st_ff;
reg [1:0] nxt_st;
reg [`WWD_CW-1:0] dly_cnt_ff;
reg [1:0] wd_ff;
reg [`WWD_CW-1:0] wd_cnt_ff;
reg [`WWD_CW-1:0] wdl_ff;
reg [`WWD_CW-1:0] wdu_ff;
reg [`WWD_CW-1:0] rst_dly_ff;
reg probe_start_ff;
reg win_start_ff;

wire faults_ok;
wire kick_fall;
wire rd_pull_en;
wire rd_busy;
wire [1:0] rd_opt;
wire wt_pull_en;
wire wt_busy;
wire [1:0] wt_opt;
wire delay_done;
wire rd_is_cap;
wire probe_launch;
wire probe_done;
wire upper_hit;
wire lower_short;
wire hold_done;
wire cal_ready;
wire cal_hit;
wire kick_bad;
wire wd_running;
wire win_probe_go;
wire [`WWD_CW-1:0] wd_cnt_inc;
reg nxt_rd_pd;

assign faults_ok = supply_above_uvlo_i & sense_in_window_i;

// --------------------------------------------------------------
// pin probes and kick edge
// --------------------------------------------------------------
wwd_pin_probe u_rd_probe (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.start_i(probe_start_ff),
	.pin_level_i(reset_delay_pin_i),
	.pull_en_o(rd_pull_en),
	.busy_o(rd_busy),
	.opt_o(rd_opt)
);

wwd_pin_probe u_wt_probe (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.start_i(win_start_ff),
	.pin_level_i(window_time_pin_i),
	.pull_en_o(wt_pull_en),
	.busy_o(wt_busy),
	.opt_o(wt_opt)
);

wwd_kick_detect u_kick (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.kick_i(watchdog_kick_in_i),
	.fall_o(kick_fall)
);

// --------------------------------------------------------------
// reset sequencing
// --------------------------------------------------------------
assign rd_is_cap = (rd_opt == `WWD_OPT_CAP);
assign probe_launch = (st_ff != ST_PROBE) && (nxt_st == ST_PROBE);
// probe result is valid once the probe has run and gone idle
assign probe_done = (st_ff == ST_PROBE) && !rd_busy && !probe_start_ff;

// capacitor mode ends on pin threshold, bounded by the supported range
assign delay_done = rd_is_cap ?
	((reset_delay_pin_i && dly_cnt_ff >= `WWD_CAP_MIN_CYC - 1) ||
	dly_cnt_ff >= `WWD_CAP_MAX_CYC - 1) :
	(dly_cnt_ff >= rst_dly_ff - 32'h1);

always @* begin
	nxt_st = st_ff;
	case (st_ff)
		ST_HOLD: nxt_st = ST_PROBE;
		ST_PROBE: begin
			if (!probe_start_ff && !rd_busy)
				nxt_st = faults_ok ? ST_DELAY : ST_PROBE;
		end
		ST_DELAY: begin
			if (!faults_ok)
				nxt_st = ST_HOLD;
			else if (delay_done)
				nxt_st = ST_RUN;
		end
		ST_RUN: begin
			if (!faults_ok)
				nxt_st = ST_HOLD;
		end
		default: nxt_st = ST_HOLD;
	endcase
end

// pulldown during the probe's discharge window, then held on a capacitor while reset is asserted, until the release delay starts
always @* begin
	nxt_rd_pd = rd_pull_en;
	if (rd_is_cap && nxt_st != ST_DELAY && nxt_st != ST_RUN && !rd_busy && !probe_start_ff)
		nxt_rd_pd = 1'b1;
end

always @(posedge sys_clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		st_ff <= ST_HOLD;
		dly_cnt_ff <= 32'h0;
		probe_start_ff <= 1'b0;
		rst_dly_ff <= `WWD_RST_OPEN_CYC;
		system_reset_n_o <= 1'b0;
		reset_delay_pin_o <= 1'b0;
		reset_delay_pin_oe_o <= 1'b0;
		delay_charge_en_o <= 1'b0;
	end else begin
		st_ff <= nxt_st;
		probe_start_ff <= probe_launch;
		dly_cnt_ff <= (st_ff == ST_DELAY) ? dly_cnt_ff + 32'h1 : 32'h0;
		if (probe_done) begin
			if (rd_opt == `WWD_OPT_PULL)
				rst_dly_ff <= `WWD_RST_PULL_CYC;
			else
				rst_dly_ff <= `WWD_RST_OPEN_CYC;
		end
		system_reset_n_o <= (nxt_st == ST_RUN);
		// in capacitor mode discharge while reset is asserted, except while probing and during the release delay
		reset_delay_pin_o <= 1'b0;
		reset_delay_pin_oe_o <= nxt_rd_pd;
		delay_charge_en_o <= rd_is_cap && (nxt_st == ST_DELAY);
	end
end

// --------------------------------------------------------------
// window bound compares
// --------------------------------------------------------------
// the upper and hold compares sit one short of the bound so the hit lands on its last cycle
assign wd_cnt_inc = wd_cnt_ff + 32'h1;
assign upper_hit = (wd_cnt_ff >= wdu_ff - 32'h1);
assign lower_short = (wd_cnt_ff < wdl_ff);
assign hold_done = (wd_cnt_ff >= rst_dly_ff - 32'h1);
assign cal_ready = !wt_busy && !win_start_ff;
assign cal_hit = window_time_pin_i && (wd_cnt_ff != 32'h0);
// a kick inside the lower bound, or silence past the upper bound
assign kick_bad = (kick_fall && lower_short) || (!kick_fall && upper_hit);
assign wd_running = (st_ff == ST_RUN);
assign win_probe_go = (st_ff == ST_PROBE) && probe_start_ff;

// --------------------------------------------------------------
// window watchdog
// --------------------------------------------------------------
always @(posedge sys_clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		wd_ff <= WD_CAL;
		wd_cnt_ff <= 32'h0;
		wdl_ff <= `WWD_WDL_FAC_CYC;
		wdu_ff <= `WWD_WDU_FAC_CYC;
		win_start_ff <= 1'b0;
		watchdog_fault_n_o <= 1'b1;
		watchdog_fault_n_oe_o <= 1'b0;
		window_time_pin_o <= 1'b0;
		window_time_pin_oe_o <= 1'b0;
		window_charge_en_o <= 1'b0;
	end else begin
		win_start_ff <= 1'b0;
		window_time_pin_o <= 1'b0;
		window_time_pin_oe_o <= wt_pull_en;
		window_charge_en_o <= 1'b0;
		if (!wd_running) begin
			// kicks ignored, fault released, window pin re-evaluated
			wd_ff <= WD_CAL;
			wd_cnt_ff <= 32'h0;
			watchdog_fault_n_o <= 1'b1;
			watchdog_fault_n_oe_o <= 1'b0;
			if (win_probe_go)
				win_start_ff <= 1'b1;
		end else begin
			case (wd_ff)
				WD_CAL: begin
					// timeout from window pin option, measured if a capacitor
					if (cal_ready) begin
						if (wt_opt == `WWD_OPT_CAP) begin
							window_charge_en_o <= 1'b1;
							wd_cnt_ff <= wd_cnt_inc;
							if (cal_hit) begin
								wdu_ff <= wd_cnt_ff;
								wdl_ff <= wd_cnt_ff >> `WWD_CAP_LOW_SHIFT;
								wd_cnt_ff <= 32'h0;
								wd_ff <= WD_FIRST;
							end
						end else begin
							wdl_ff <= `WWD_WDL_FAC_CYC;
							wdu_ff <= `WWD_WDU_FAC_CYC;
							wd_cnt_ff <= 32'h0;
							wd_ff <= WD_FIRST;
						end
					end
				end
				WD_FIRST: begin
					wd_cnt_ff <= wd_cnt_inc;
					if (kick_fall) begin
						wd_cnt_ff <= 32'h0;
						wd_ff <= WD_WIN;
					end else if (upper_hit) begin
						wd_cnt_ff <= 32'h0;
						watchdog_fault_n_o <= 1'b0;
						watchdog_fault_n_oe_o <= 1'b1;
						wd_ff <= WD_FAULT;
					end
				end
				WD_WIN: begin
					wd_cnt_ff <= wd_cnt_inc;
					if (kick_bad) begin
						wd_cnt_ff <= 32'h0;
						watchdog_fault_n_o <= 1'b0;
						watchdog_fault_n_oe_o <= 1'b1;
						wd_ff <= WD_FAULT;
					end else if (kick_fall) begin
						wd_cnt_ff <= 32'h0;
					end
				end
				WD_FAULT: begin
					wd_cnt_ff <= wd_cnt_inc;
					if (hold_done) begin
						wd_cnt_ff <= 32'h0;
						watchdog_fault_n_o <= 1'b1;
						watchdog_fault_n_oe_o <= 1'b0;
						wd_ff <= WD_FIRST;
					end
				end
				default: wd_ff <= WD_CAL;
			endcase
		end
	end
end

endmodule
`default_nettype wire

// file: tb/wwd_board_model.sv
// board capacitors on the two timing pins
`timescale 1ns/10ps
`default_nettype none
module wwd_board_model #(parameter int RST_N = 17500, parameter int WD_N = 800) (
	// clock
	input wire logic clk_i,
	// pin controls
	input wire logic rst_pd_i,
	input wire logic rst_chg_i,
	input wire logic wd_pd_i,
	input wire logic wd_chg_i,
	// pin levels
	output logic rst_pin_o,
	output logic wd_pin_o
);
	int rst_v_ff = 0;
	int wd_v_ff = 0;
	always @(posedge clk_i) begin
		if (rst_pd_i) rst_v_ff <= 0;
		else if (rst_chg_i) rst_v_ff <= rst_v_ff + 1;
		if (wd_pd_i) wd_v_ff <= 0;
		else if (wd_chg_i) wd_v_ff <= wd_v_ff + 1;
	end
	// no charge held: pin stays low
	assign rst_pin_o = rst_v_ff >= RST_N;
	assign wd_pin_o = wd_v_ff >= WD_N;
endmodule
`default_nettype wire

// file: tb/wwd_top_props.sv
// assertions on the watchdog block ports
`timescale 1ns/10ps
`default_nettype none
module wwd_props (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// inputs
	input wire logic supply_above_uvlo_i,
	input wire logic sense_in_window_i,
	// outputs
	input wire logic reset_delay_pin_o,
	input wire logic reset_delay_pin_oe_o,
	input wire logic delay_charge_en_o,
	input wire logic system_reset_n_o,
	input wire logic watchdog_fault_n_o,
	input wire logic watchdog_fault_n_oe_o
);
	int lo_cnt_ff;
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) lo_cnt_ff <= 0;
		else if (system_reset_n_o) lo_cnt_ff <= 0;
		else lo_cnt_ff <= lo_cnt_ff + 1;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_fault_on;
		$rose(watchdog_fault_n_oe_o);
	endsequence
	sequence s_fault_held;
		(watchdog_fault_n_oe_o || !system_reset_n_o)[*8];
	endsequence
	rst_rel_a: assert property (!system_reset_n_o[*2] |-> !watchdog_fault_n_oe_o)
		else $error("fault driven in reset");
	uvlo_rst_a: assert property (!supply_above_uvlo_i |-> ##[1:3] !system_reset_n_o)
		else $error("reset missed on low supply");
	sense_rst_a: assert property (!sense_in_window_i |-> ##[1:3] !system_reset_n_o)
		else $error("reset missed on sense");
	fault_low_a: assert property (watchdog_fault_n_oe_o |-> !watchdog_fault_n_o)
		else $error("fault driven high");
	pd_val_a: assert property (reset_delay_pin_oe_o |-> !reset_delay_pin_o)
		else $error("pulldown value wrong");
	probe_len_a: assert property ($rose(system_reset_n_o) |-> lo_cnt_ff >= 9525)
		else $error("reset released too soon");
	kick_ign_a: assert property (s_fault_on |-> $past(system_reset_n_o))
		else $error("fault raised in reset");
	fault_hold_a: assert property (s_fault_on |-> s_fault_held)
		else $error("fault dropped early");
	chg_off_a: assert property ($rose(system_reset_n_o) |-> ##[0:2] !delay_charge_en_o)
		else $error("charge left on");
	pd_chg_a: assert property (!(reset_delay_pin_oe_o && delay_charge_en_o))
		else $error("pulldown and charge together");
endmodule
bind wwd_top wwd_props i_wwd_props (.sys_clk_i, .rst_b_i, .supply_above_uvlo_i,
	.sense_in_window_i, .reset_delay_pin_o, .reset_delay_pin_oe_o, .delay_charge_en_o,
	.system_reset_n_o, .watchdog_fault_n_o, .watchdog_fault_n_oe_o);
`default_nettype wire

// file: tb/tb_top.sv
// testbench for the window watchdog block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk_i = 0, rst_b_i = 0, supply_above_uvlo_i = 1, sense_in_window_i = 1;
	logic watchdog_kick_in_i = 1, reset_delay_pin_i, window_time_pin_i;
	logic reset_delay_pin_oe_o, delay_charge_en_o, window_time_pin_oe_o, window_charge_en_o;
	logic system_reset_n_o, watchdog_fault_n_o, watchdog_fault_n_oe_o;
	int n_mismatch = 0, n_tests = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	wwd_top i_wwd_top (.sys_clk_i, .rst_b_i, .supply_above_uvlo_i, .sense_in_window_i,
		.watchdog_kick_in_i, .reset_delay_pin_i, .reset_delay_pin_o(),
		.reset_delay_pin_oe_o, .delay_charge_en_o, .window_time_pin_i,
		.window_time_pin_o(), .window_time_pin_oe_o, .window_charge_en_o,
		.system_reset_n_o, .watchdog_fault_n_o, .watchdog_fault_n_oe_o);
	wwd_board_model i_wwd_board_model (.clk_i(sys_clk_i), .rst_pd_i(reset_delay_pin_oe_o),
		.rst_chg_i(delay_charge_en_o), .wd_pd_i(window_time_pin_oe_o),
		.wd_chg_i(window_charge_en_o), .rst_pin_o(reset_delay_pin_i),
		.wd_pin_o(window_time_pin_i));
	// ----
	// shared tasks
	// ----
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input bit w, input logic v, input int lim);
		int k;
		k = 0;
		while ((w ? watchdog_fault_n_oe_o : system_reset_n_o) !== v) begin
			@(negedge sys_clk_i);
			k++;
			if (k > lim) begin
				n_mismatch++;
				$display("[FAIL] t=%0t wait ran out, want %h", $time, v);
				report_and_stop();
			end
		end
	endtask
	// short low pulse: its rising edge must not count
	task kick(input int gap);
		repeat (gap) @(negedge sys_clk_i);
		watchdog_kick_in_i = 0;
		repeat (5) @(negedge sys_clk_i);
		watchdog_kick_in_i = 1;
	endtask
	// ----
	// scenarios
	// ----
	task t_boot();
		repeat (520) kick(45);
		chk(system_reset_n_o, 0);
		chk(watchdog_fault_n_oe_o, 0);
		chk(delay_charge_en_o, 1);
		wt(0, 1, 3000);
	endtask
	task t_good();
		repeat (3) @(negedge sys_clk_i);
		chk(window_charge_en_o, 1);
		repeat (12) begin
			kick(395);
			chk(watchdog_fault_n_oe_o, 0);
		end
	endtask
	task t_early();
		kick(30);
		wt(1, 1, 5);
		chk(watchdog_fault_n_o, 0);
		repeat (500) @(negedge sys_clk_i);
		chk(watchdog_fault_n_oe_o, 1);
		supply_above_uvlo_i = 0;
		repeat (100) @(negedge sys_clk_i);
		chk(system_reset_n_o, 0);
		chk(watchdog_fault_n_oe_o, 0);
		chk(reset_delay_pin_oe_o, 1);
		chk(window_time_pin_oe_o, 1);
		supply_above_uvlo_i = 1;
		wt(0, 1, 30000);
	endtask
	task t_late();
		t_good();
		wt(1, 1, 1000);
		sense_in_window_i = 0;
		repeat (5) @(negedge sys_clk_i);
		chk(system_reset_n_o, 0);
		chk(watchdog_fault_n_oe_o, 0);
	endtask
	initial begin
		repeat (12) @(negedge sys_clk_i);
		rst_b_i = 1;
		t_boot();
		t_good();
		t_early();
		t_late();
		report_and_stop();
	end
endmodule
`default_nettype wire
